//--- logic/zar_readout.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Convert 10-bit raw acceleration, sleeping in deep stop until converter completes.
// - Five consecutive foreign wake-ups abandon the conversion with a failure flag.
// - Low-voltage warning appears in status as 20, 30 or A0.
// - Out-of-span average sets range error and rails value to 3ff or 0.
// - Converter timeout gives status 80 and a zero value.
// - Status 00 means value 001..3fe; 10 means Z railed.
// - Failure with low-voltage warning gives A0 and zero value.
// - Single read averages 1, 2, 4, 8 or 16 samples; others refused.
// - Filter select set picks 250 Hz, clear picks 500 Hz.
// - Dynamic mode retries with new steps until valid or steps exhausted.
// - Exhausted search returns step 255 below zero or 16 above 15.
// - Compensation yields 9 bits, rails to 1 or 1fe, flags 01.
// - Low raw voltage flags 20, or 21 with overflow.
// - Compensation runs in run state, ignoring interrupts.
// - Raw read updates only the raw acceleration entries.
// - Combined read also accepts an average of 32.
// - Combined status: 08 X range, 10 Z range, 18 both, plus 20.
module zar_readout
  import zar_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Converter and wake-up sources
  input  wire logic        convDonePin,
  input  wire logic        foreignIrqPin,
  input  wire logic        lowVoltPin,
  input  wire logic [9:0]  convData,
  // Measurement interface control
  output var  logic        convStart,
  output var  logic        filterNarrow,
  output var  logic [3:0]  offsetStepOut,
  output var  logic        axisZSel,
  output var  logic        deepStopWait,
  output var  logic        opDone
);

  typedef enum {S_IDLE, S_LAUNCH, S_WAIT, S_JUDGE, S_COMP, S_FINISH}
    zar_state_t;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic       doneS1, doneS2, doneS3;
  logic       forS1, forS2, forS3;
  logic       lvS1, lvS2;
  logic [9:0] dataS1, dataS2;
  logic       doneEv, foreignEv;

  // First stages feed only second stages
  always_ff @(posedge clock) begin
    if (reset) begin
      {doneS1, doneS2, doneS3} <= 3'h0;
      {forS1, forS2, forS3}    <= 3'h0;
      {lvS1, lvS2}             <= 2'h0;
      dataS1                   <= 10'h000;
      dataS2                   <= 10'h000;
    end else begin
      {doneS1, doneS2, doneS3} <= {convDonePin, doneS1, doneS2};
      {forS1, forS2, forS3}    <= {foreignIrqPin, forS1, forS2};
      {lvS1, lvS2}             <= {lowVoltPin, lvS1};
      dataS1                   <= convData;
      dataS2                   <= dataS1;
    end
  end

  // Rising edges on the settled stages
  assign doneEv    = doneS2 & ~doneS3;
  assign foreignEv = forS2 & ~forS3;

  // ---------------------------------------------------------------
  // APB response
  // ---------------------------------------------------------------
  logic        wrEn;
  logic        next_pready, next_pslverr;
  logic [31:0] next_prdata;
  zar_state_t  state, next_state;
  logic [7:0]  resultStatus, zStep, xStep;
  logic [9:0]  rawZ, rawX, voltEntry, tempEntry;
  logic [8:0]  compOut;
  logic        refused;

  // Zero wait states: answer in the first access cycle
  assign wrEn = psel & penable & pready & pwrite;

  always_comb begin
    next_pready  = psel & ~penable;
    next_pslverr = 1'b0;
    next_prdata  = 32'h0000_0000;
    if (psel & ~penable) begin
      case (paddr)
        ADDR_CTRL:    next_prdata = 32'h0000_0000;
        ADDR_STEP:    next_prdata[15:0] = {xStep, zStep};
        ADDR_STATUS: begin
          next_prdata[7:0]        = resultStatus;
          next_prdata[ST_BUSY]    = (state != S_IDLE);
          next_prdata[ST_REFUSED] = refused;
        end
        ADDR_RAW_ACC: next_prdata = {6'h00, rawX, 6'h00, rawZ};
        ADDR_RAW_VT:  next_prdata = {6'h00, tempEntry, 6'h00, voltEntry};
        ADDR_COMP:    next_prdata[8:0] = compOut;
        default:      next_pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= next_pready;
      pslverr <= next_pslverr;
      prdata  <= next_prdata;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  logic [1:0]  op, next_op;
  logic        dyn, next_dyn, axisZ, next_axisZ;
  logic [5:0]  avgCount, next_avgCount, sampleCnt, next_sampleCnt;
  logic [2:0]  avgShift, next_avgShift, foreignCnt, next_foreignCnt;
  logic [14:0] accum, next_accum, shifted;
  logic [9:0]  avgVal, next_rawZ, next_rawX, next_volt, next_temp;
  logic [7:0]  next_status, next_zStep, next_xStep;
  logic [8:0]  next_compOut;
  logic        next_refused, next_convStart, next_filter, next_axisSel;
  logic        next_deepStop, next_opDone, next_compStart;
  logic [3:0]  next_stepOut, avgCode;
  logic        railHi, railLo, compDone, compStart;
  logic [8:0]  compVal;
  logic [7:0]  compStat;

  // Average count to {valid, shift}; 32 only for combined read
  function automatic logic [3:0] avg_code(input logic [5:0] n,
                                          input logic       wide);
    case (n)
      6'h01:   avg_code = 4'h8;
      6'h02:   avg_code = 4'h9;
      6'h04:   avg_code = 4'ha;
      6'h08:   avg_code = 4'hb;
      6'h10:   avg_code = 4'hc;
      6'h20:   avg_code = wide ? 4'hd : 4'h0;
      default: avg_code = 4'h0;
    endcase
  endfunction

  assign avgCode = avg_code(pwdata[CTRL_AVG_LO +: 6],
                            pwdata[CTRL_OP_LO +: 2] == OP_READ_XZ);
  assign shifted = accum >> avgShift;
  assign avgVal  = shifted[9:0];
  assign railHi  = (avgVal == RAW_MAX);
  assign railLo  = (avgVal == RAW_MIN);

  always_comb begin
    next_state = state;         next_op = op;
    next_dyn = dyn;             next_axisZ = axisZ;
    next_avgCount = avgCount;   next_avgShift = avgShift;
    next_sampleCnt = sampleCnt; next_foreignCnt = foreignCnt;
    next_accum = accum;         next_rawZ = rawZ;
    next_rawX = rawX;           next_volt = voltEntry;
    next_temp = tempEntry;      next_status = resultStatus;
    next_zStep = zStep;         next_xStep = xStep;
    next_compOut = compOut;     next_refused = refused;
    next_filter = filterNarrow; next_axisSel = axisZSel;
    next_stepOut = offsetStepOut;
    next_deepStop = deepStopWait;
    next_convStart = 1'b0;
    next_opDone = 1'b0;
    next_compStart = 1'b0;
    // Register writes only while idle, so a run sees stable inputs
    if (wrEn && state == S_IDLE) begin
      case (paddr)
        ADDR_CTRL: if (pwdata[CTRL_START]) begin
          next_op = pwdata[CTRL_OP_LO +: 2];
          if (next_op == OP_COMP) begin
            next_compStart = 1'b1;
            next_state = S_COMP;
            next_refused = 1'b0;
          end else if (avgCode[3] && next_op != 2'h3) begin
            next_dyn = pwdata[CTRL_DYN] && next_op == OP_READ_Z;
            next_filter = pwdata[CTRL_FILT];
            next_avgCount = pwdata[CTRL_AVG_LO +: 6];
            next_avgShift = avgCode[2:0];
            next_axisZ = (next_op == OP_READ_Z);
            next_accum = 15'h0000;
            next_sampleCnt = 6'h00;
            next_foreignCnt = 3'h0;
            next_status = 8'h00;
            next_refused = 1'b0;
            next_state = S_LAUNCH;
          end else begin
            next_refused = 1'b1;
          end
        end
        ADDR_STEP: begin
          next_zStep = {4'h0, pwdata[3:0]};
          next_xStep = {4'h0, pwdata[STEP_X_LO +: 4]};
        end
        ADDR_RAW_VT: begin
          next_volt = pwdata[9:0];
          next_temp = pwdata[HI_LO +: 10];
        end
        default: ;
      endcase
    end
    case (state)
      S_IDLE: ;
      S_LAUNCH: begin
        next_convStart = 1'b1;
        next_deepStop = 1'b1;
        next_axisSel = axisZ;
        next_stepOut = axisZ ? zStep[3:0] : xStep[3:0];
        next_state = S_WAIT;
      end
      S_WAIT: begin
        if (doneEv) begin
          next_deepStop = 1'b0;
          next_foreignCnt = 3'h0;
          next_accum = accum + {5'h00, dataS2};
          next_sampleCnt = sampleCnt + 6'h01;
          next_state = (next_sampleCnt == avgCount) ? S_JUDGE : S_LAUNCH;
        end else if (foreignEv) begin
          next_foreignCnt = foreignCnt + 3'h1;
          if (next_foreignCnt == FOREIGN_LIMIT) begin
            next_deepStop = 1'b0;
            // Drop an X range flag: failure code is only 80 or a0
            next_status = 8'h00;
            next_status[ST_CONV_FAIL] = 1'b1;
            next_status[ST_LOW_VOLT] = lvS2;
            if (axisZ) next_rawZ = RAW_MIN;
            else next_rawX = RAW_MIN;
            next_state = S_FINISH;
          end
        end
      end
      S_JUDGE: begin
        next_accum = 15'h0000;
        next_sampleCnt = 6'h00;
        if (dyn && railHi && zStep < STEP_MAX) begin
          next_zStep = zStep + 8'h01;
          next_state = S_LAUNCH;
        end else if (dyn && railLo && zStep != 8'h00) begin
          next_zStep = zStep - 8'h01;
          next_state = S_LAUNCH;
        end else begin
          if (dyn && railHi) next_zStep = STEP_OVER;
          if (dyn && railLo) next_zStep = STEP_UNDER;
          if (axisZ) next_rawZ = avgVal;
          else next_rawX = avgVal;
          if (railHi || railLo) begin
            if (axisZ) next_status[ST_Z_RANGE] = 1'b1;
            else next_status[ST_X_RANGE] = 1'b1;
          end
          if (lvS2) next_status[ST_LOW_VOLT] = 1'b1;
          next_axisZ = 1'b1;
          next_state = axisZ ? S_FINISH : S_LAUNCH;
        end
      end
      S_COMP: if (compDone) begin
        next_compOut = compVal;
        next_status = compStat;
        next_state = S_FINISH;
      end
      S_FINISH: begin
        next_opDone = 1'b1;
        next_state = S_IDLE;
      end
      default: next_state = S_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clock) begin
    if (reset) begin
      state <= S_IDLE;          op <= OP_READ_Z;
      dyn <= 1'b0;              axisZ <= 1'b1;
      avgCount <= 6'h01;        avgShift <= 3'h0;
      sampleCnt <= 6'h00;       foreignCnt <= 3'h0;
      accum <= 15'h0000;        rawZ <= 10'h000;
      rawX <= 10'h000;          voltEntry <= 10'h000;
      tempEntry <= 10'h000;     resultStatus <= 8'h00;
      zStep <= 8'h00;           xStep <= 8'h00;
      compOut <= 9'h000;        refused <= 1'b0;
      convStart <= 1'b0;        filterNarrow <= 1'b0;
      offsetStepOut <= 4'h0;    axisZSel <= 1'b0;
      deepStopWait <= 1'b0;     opDone <= 1'b0;
      compStart <= 1'b0;
    end else begin
      state <= next_state;          op <= next_op;
      dyn <= next_dyn;              axisZ <= next_axisZ;
      avgCount <= next_avgCount;    avgShift <= next_avgShift;
      sampleCnt <= next_sampleCnt;  foreignCnt <= next_foreignCnt;
      accum <= next_accum;          rawZ <= next_rawZ;
      rawX <= next_rawX;            voltEntry <= next_volt;
      tempEntry <= next_temp;       resultStatus <= next_status;
      zStep <= next_zStep;          xStep <= next_xStep;
      compOut <= next_compOut;      refused <= next_refused;
      convStart <= next_convStart;  filterNarrow <= next_filter;
      offsetStepOut <= next_stepOut; axisZSel <= next_axisSel;
      deepStopWait <= next_deepStop; opDone <= next_opDone;
      compStart <= next_compStart;
    end
  end

  // Compensation uses the stored Z entry
  zar_comp u_comp (
    .clock       (clock),
    .reset       (reset),
    .start       (compStart),
    .voltage     (voltEntry),
    .temperature (tempEntry),
    .accel       (rawZ),
    .done        (compDone),
    .value       (compVal),
    .status      (compStat)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_stop_on_start: assert property (@(posedge clock) disable iff (reset)
    convStart |-> deepStopWait ##1 deepStopWait)
    else $error("conversion started outside deep stop");
  a_fail_fifth: assert property (@(posedge clock) disable iff (reset)
    state == S_WAIT && foreignEv && !doneEv && foreignCnt == 3'h4
      |=> state == S_FINISH && resultStatus[ST_CONV_FAIL])
    else $error("fifth foreign wake-up did not end the read");
  a_fail_value: assert property (@(posedge clock) disable iff (reset)
    opDone && resultStatus[ST_CONV_FAIL] && op == OP_READ_Z
      |-> rawZ == RAW_MIN)
    else $error("failed conversion left nonzero value");
  a_fail_code: assert property (@(posedge clock) disable iff (reset)
    opDone && resultStatus[ST_CONV_FAIL]
      |-> resultStatus == 8'h80 || resultStatus == 8'ha0)
    else $error("failure status not 80 or a0");
  a_valid_span: assert property (@(posedge clock) disable iff (reset)
    opDone && op == OP_READ_Z && resultStatus == 8'h00
      |-> rawZ > RAW_MIN && rawZ < RAW_MAX)
    else $error("status 00 with railed value");
  a_range_rail: assert property (@(posedge clock) disable iff (reset)
    opDone && op == OP_READ_Z && resultStatus[ST_Z_RANGE]
      |-> rawZ == RAW_MAX || rawZ == RAW_MIN)
    else $error("range error without railed value");
  a_filter_hold: assert property (@(posedge clock) disable iff (reset)
    state == S_WAIT |-> $stable(filterNarrow))
    else $error("filter changed during conversion");
  a_avg_count: assert property (@(posedge clock) disable iff (reset)
    state == S_JUDGE |-> sampleCnt == avgCount && $past(doneEv))
    else $error("judged before averaging completed");
  a_step_codes: assert property (@(posedge clock) disable iff (reset)
    opDone && dyn |-> zStep <= STEP_MAX || zStep == STEP_OVER
      || zStep == STEP_UNDER)
    else $error("dynamic step outside legal codes");
  a_entries_kept: assert property (@(posedge clock) disable iff (reset)
    state != S_IDLE |=> $stable(voltEntry) && $stable(tempEntry))
    else $error("raw read disturbed voltage or temperature");

  c_dyn_retry: cover property (@(posedge clock) disable iff (reset)
    state == S_JUDGE && dyn ##1 state == S_LAUNCH);
  c_xz_done: cover property (@(posedge clock) disable iff (reset)
    opDone && op == OP_READ_XZ);
  c_fail: cover property (@(posedge clock) disable iff (reset)
    opDone && resultStatus[ST_CONV_FAIL]);
  c_comp: cover property (@(posedge clock) disable iff (reset)
    opDone && op == OP_COMP);

endmodule
`default_nettype wire

//--- inc/zar_pkg.sv
// ---------------------------------------------------------------
// Shared constants of the Z-axis readout
// ---------------------------------------------------------------
package zar_pkg;

  // Register byte addresses on the APB window
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STEP     = 8'h04;
  localparam logic [7:0] ADDR_STATUS   = 8'h08;
  localparam logic [7:0] ADDR_RAW_ACC  = 8'h0c;
  localparam logic [7:0] ADDR_RAW_VT   = 8'h10;
  localparam logic [7:0] ADDR_COMP     = 8'h14;

  // Control, step and raw entry word fields
  localparam int CTRL_START  = 0;
  localparam int CTRL_OP_LO  = 1;
  localparam int CTRL_DYN    = 3;
  localparam int CTRL_FILT   = 4;
  localparam int CTRL_AVG_LO = 8;
  localparam int STEP_X_LO   = 8;
  localparam int HI_LO       = 16;

  // Operation codes
  localparam logic [1:0] OP_READ_Z  = 2'h0;
  localparam logic [1:0] OP_READ_XZ = 2'h1;
  localparam logic [1:0] OP_COMP    = 2'h2;

  // Status word flag positions; busy and refused sit above the byte
  localparam int ST_CONV_FAIL = 7;
  localparam int ST_LOW_VOLT  = 5;
  localparam int ST_Z_RANGE   = 4;
  localparam int ST_X_RANGE   = 3;
  localparam int ST_COMP_OVF  = 0;
  localparam int ST_BUSY      = 8;
  localparam int ST_REFUSED   = 9;

  // Raw and compensated limits
  localparam logic [9:0] RAW_MAX  = 10'h3ff;
  localparam logic [9:0] RAW_MIN  = 10'h000;
  localparam logic [8:0] COMP_MIN = 9'h001;
  localparam logic [8:0] COMP_MAX = 9'h1fe;

  // Offset step limits and exhausted-search codes
  localparam logic [7:0] STEP_MAX   = 8'h0f;
  localparam logic [7:0] STEP_UNDER = 8'hff;
  localparam logic [7:0] STEP_OVER  = 8'h10;

  // Consecutive foreign wake-ups before a conversion is abandoned
  localparam logic [2:0] FOREIGN_LIMIT = 3'h5;

  // Compensation reference points
  localparam logic [9:0] TEMP_REF = 10'h200;
  localparam logic [9:0] VOLT_MIN = 10'h100;

endpackage

//--- logic/zar_comp.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Compensation stage: raw volt, temp, accel to 9-bit value
// ---------------------------------------------------------------
module zar_comp
  import zar_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  // Request
  input  wire logic       start,
  input  wire logic [9:0] voltage,
  input  wire logic [9:0] temperature,
  input  wire logic [9:0] accel,
  // Answer
  output var  logic       done,
  output var  logic [8:0] value,
  output var  logic [7:0] status
);

  logic signed [12:0] sum;
  logic [8:0]         next_value;
  logic [7:0]         next_status;

  // Single pass in run state, no interrupt dependency
  always_comb begin
    sum = $signed({4'h0, accel[9:1]})
        + (($signed({3'h0, temperature}) - $signed({3'h0, TEMP_REF})) >>> 3);
    next_status = 8'h00;
    next_value  = sum[8:0];
    if (sum < $signed({4'h0, COMP_MIN})) begin
      next_value = COMP_MIN;
      next_status[ST_COMP_OVF] = 1'b1;
    end else if (sum > $signed({4'h0, COMP_MAX})) begin
      next_value = COMP_MAX;
      next_status[ST_COMP_OVF] = 1'b1;
    end
    // Low supply only degrades accuracy, result still returned
    if (voltage < VOLT_MIN) begin
      next_status[ST_LOW_VOLT] = 1'b1;
    end
  end

  // Result registers
  always_ff @(posedge clock) begin
    if (reset) begin
      done   <= 1'b0;
      value  <= 9'h000;
      status <= 8'h00;
    end else begin
      done <= start;
      if (start) begin
        value  <= next_value;
        status <= next_status;
      end
    end
  end

  a_comp_range: assert property (@(posedge clock) disable iff (reset)
    done |-> value >= COMP_MIN && value <= COMP_MAX)
    else $error("compensated value outside 1..1fe");
  a_comp_ovf_rail: assert property (@(posedge clock) disable iff (reset)
    done && status[ST_COMP_OVF] |-> value == COMP_MIN || value == COMP_MAX)
    else $error("overflow flagged without rail value");
  a_comp_latency: assert property (@(posedge clock) disable iff (reset)
    start |=> done ##1 !done)
    else $error("compensation not answered in one cycle");

endmodule
`default_nettype wire

//--- verification/zar_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Converter and wake-up source model
// ---------------------------------------------------------------
module zar_conv_model (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  // Bench controls
  input  wire logic [9:0] sample,
  input  wire logic       failMode,
  input  wire logic [3:0] delay,
  // Link to the readout
  input  wire logic       convStart,
  output var  logic       convDonePin,
  output var  logic       foreignIrqPin,
  output var  logic [9:0] convData
);
  logic [6:0] cnt;

  // Countdown per conversion; a hung converter sends only foreign edges
  always_ff @(posedge clock) begin
    if (reset) begin
      cnt      <= 7'h00;
      convData <= 10'h000;
    end else if (convStart) begin
      cnt      <= failMode ? 7'h30 : 7'h0c + {1'b0, delay, 2'b00};
      convData <= sample;
    end else if (cnt != 7'h00) begin
      cnt <= cnt - 7'h01;
      // Hold time over: scramble so a late sample is caught
      if (cnt == 7'h01) begin
        convData <= ~convData;
      end
    end
  end

  // Done only after data has settled for several cycles
  assign convDonePin   = !failMode && cnt >= 7'h05 && cnt <= 7'h08;
  assign foreignIrqPin = failMode && cnt[2];
endmodule
`default_nettype wire

//--- verification/test_z_axis_accel_readout.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED %0t got %0h exp %0h", $time, g, e); end end
// ---------------------------------------------------------------
// Self-checking bench of the Z-axis readout
// ---------------------------------------------------------------
module test_z_axis_accel_readout;
  import zar_pkg::*;
  logic        clock, reset, psel, penable, pwrite, pready, pslverr, se;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r, st, raw;
  logic        convDonePin, foreignIrqPin, lowVoltPin, convStart;
  logic        filterNarrow, axisZSel, deepStopWait, opDone, failMode;
  logic [9:0]  convData, sample, v, t, vt, e;
  logic [3:0]  offsetStepOut, delay, lastStep, xStep, xs, zs;
  logic        lastFilt, lv, f;
  int          err_count, cmp_count, cyc, nStarts;
  int          avgs[5] = '{1, 2, 4, 8, 16};
  logic [31:0] bad[2] = '{32'h2001, 32'h0107};

  zar_readout zar_readout_inst (.clock, .reset, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .convDonePin,
    .foreignIrqPin, .lowVoltPin, .convData, .convStart, .filterNarrow,
    .offsetStepOut, .axisZSel, .deepStopWait, .opDone);
  zar_conv_model zar_conv_model_inst (.clock, .reset, .sample, .failMode,
    .delay, .convStart, .convDonePin, .foreignIrqPin, .convData);

  // Closing report, also reached by the hang guard
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Start one operation, wait for its end, fetch status and raw word
  task automatic op(input logic [1:0] o, input logic dy, input logic fl,
                    input int n);
    nStarts = 0;
    delay <= 4'($urandom);
    apb(1'b1, ADDR_CTRL, 32'(n << CTRL_AVG_LO) | 32'({fl, dy, o, 1'b1}), r);
    // A lost operation is ended by the hang guard
    do @(posedge clock); while (opDone !== 1'b1);
    apb(1'b0, ADDR_STATUS, 32'h0, st);
    apb(1'b0, ADDR_RAW_ACC, 32'h0, raw);
  endtask

  // Compensation reference: 9-bit value with overflow flag on top
  function automatic logic [9:0] cexp(input int a, input int tt);
    int s;
    s = a / 2 + (tt - 512) / 8;
    if (s < 1) return {1'b1, COMP_MIN};
    if (s > 510) return {1'b1, COMP_MAX};
    return {1'b0, s[8:0]};
  endfunction

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Hang guard and conversion monitor
  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      wrap_up();
    end
    if (convStart === 1'b1) begin
      nStarts++;
      `CHK(deepStopWait, 1'b1)
      lastFilt = filterNarrow;
      lastStep = offsetStepOut;
      if (axisZSel === 1'b0) xStep = offsetStepOut;
    end
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, lowVoltPin, failMode} = '0;
    {sample, delay} = '0;
    reset = 1'b1;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    void'($urandom(32'hea7c));
    apb(1'b0, 8'h18, 32'h0, r);
    `CHK({se, r}, 33'h100000000)
    apb(1'b1, ADDR_STEP, 32'h1f3a, r);
    apb(1'b0, ADDR_STEP, 32'h0, r);
    `CHK(r[15:0], 16'h0f0a)
    // Combined read, both axes railed, longest average
    xs = 4'($urandom);
    zs = 4'($urandom);
    lv = 1'($urandom);
    sample <= RAW_MAX;
    lowVoltPin <= lv;
    apb(1'b1, ADDR_STEP, {16'h0, 4'h0, xs, 4'h0, zs}, r);
    op(OP_READ_XZ, 1'b0, 1'b0, 32);
    `CHK(st[7:0], {2'b0, lv, 5'h18})
    `CHK(nStarts, 64)
    `CHK({xStep, lastStep}, {xs, zs})
    `CHK(raw[25:0], {RAW_MAX, 6'h0, RAW_MAX})
    // Valid single reads over every average count
    foreach (avgs[i]) begin
      v = 10'($urandom_range(1, 1022));
      {lv, f, zs} = 6'($urandom);
      sample <= v;
      lowVoltPin <= lv;
      apb(1'b1, ADDR_STEP, {28'h0, zs}, r);
      op(OP_READ_Z, 1'b0, f, avgs[i]);
      `CHK(st[7:0], {2'b0, lv, 5'h0})
      `CHK(raw[25:0], {RAW_MAX, 6'h0, v})
      `CHK(nStarts, avgs[i])
      `CHK({lastFilt, lastStep}, {f, zs})
    end
    // Rails and converter failure, with and without low voltage
    for (int k = 0; k < 4; k++) begin
      lowVoltPin <= k[0];
      failMode <= k[1];
      sample <= k[0] ? RAW_MIN : RAW_MAX;
      op(OP_READ_Z, 1'b0, 1'b0, 1);
      `CHK(st[7:0], {k[1], 1'b0, k[0], ~k[1], 4'h0})
      `CHK(raw[9:0], (k[0] | k[1]) ? RAW_MIN : RAW_MAX)
    end
    failMode <= 1'b0;
    lowVoltPin <= 1'b0;
    // Illegal average and unused operation code
    foreach (bad[i]) begin
      nStarts = 0;
      apb(1'b1, ADDR_CTRL, bad[i], r);
      apb(1'b0, ADDR_STATUS, 32'h0, st);
      `CHK({st[ST_REFUSED], 32'(nStarts)}, 33'h100000000)
    end
    // Dynamic search: exhausted high, exhausted low, settled
    for (int k = 0; k < 3; k++) begin
      zs = 4'($urandom);
      v = k == 0 ? RAW_MAX : k == 1 ? RAW_MIN : 10'h155;
      sample <= v;
      apb(1'b1, ADDR_STEP, {28'h0, zs}, r);
      op(OP_READ_Z, 1'b1, 1'b0, 1);
      apb(1'b0, ADDR_STEP, 32'h0, r);
      `CHK(r[7:0], k == 0 ? STEP_OVER : k == 1 ? STEP_UNDER : {4'h0, zs})
      `CHK({st[7:0], raw[9:0]}, {k < 2 ? 8'h10 : 8'h00, v})
      `CHK(nStarts, k == 0 ? 16 - zs : k == 1 ? zs + 1 : 1)
    end
    // Compensation corners then random points
    for (int k = 0; k < 4; k++) begin
      v = k == 0 ? 10'h3fe : k == 1 ? RAW_MIN : 10'($urandom_range(1, 1022));
      t = k == 0 ? 10'h3f8 : k == 1 ? 10'h000 : {7'($urandom), 3'h0};
      vt = k == 0 ? 10'h080 : 10'($urandom);
      sample <= v;
      op(OP_READ_Z, 1'b0, 1'b0, 1);
      apb(1'b1, ADDR_RAW_VT, {6'h0, t, 6'h0, vt}, r);
      op(OP_COMP, 1'b0, 1'b0, 1);
      apb(1'b0, ADDR_COMP, 32'h0, r);
      e = cexp(int'(v), int'(t));
      `CHK(r[8:0], e[8:0])
      `CHK(st[7:0], {2'b0, vt < VOLT_MIN, 4'h0, e[9]})
    end
    wrap_up();
  end
endmodule
`default_nettype wire
